// *** rtl/card_bridge_system_control_low.sv ***
// Lower half of the system control register with the controls it steers
`timescale 1ns/1ps

// Overview of operation
// - Downstream read bursts allowed only while control bit 15 is one; resets one.
// - Upstream read bursts allowed only while control bit 14 is one; resets zero.
// - Card access sets activity flag; a register read clears it; resets zero.
// - Position 12 always reads one and ignores writes.
// - Serial busy flag holds from power change request until stream and delay end.
// - After a power-up stream the rise wait flag sets until settling ends.
// - After a power-down stream the fall wait flag sets until settling ends.
// - Probe busy flag follows card interrogation in progress.
// - Bit 7 gates the legacy automatic power switch enable bit.
// - With bit 6 set, idle clockless CardBus card stops its state machine clock.
// - Bit 5 set makes identification registers read-only; zero makes them writable.
// - Bit 4 set routes CardBus data parity errors onto system error.
// - Bit 2 picks legacy supply voltage: zero 3.3 V, one 5 V.
// - Bit 1 set refuses clock stop through both clock-run protocols.
// - Bit 0 zero puts ring and wake on the shared pin; one wake only.
// - Shared mode with wake enabled gives ring priority; wake passes when no ring is requested.
module card_bridge_system_control_low
  import sysctl_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [1:0] i_cfg_be,
  input wire logic [15:0] i_cfg_wdata,
  input wire sys_events_t i_events,
  input wire card_status_t i_card,
  input wire logic i_legacy_auto_sw,
  input wire logic i_clkrun_stop_req,
  output logic [15:0] o_cfg_rdata,
  output logic o_down_read_burst_en,
  output logic o_up_read_burst_en,
  output logic o_auto_switch_active,
  output logic o_card_fsm_clk_en,
  output logic o_id_write_lock,
  output logic o_serr_req,
  output logic o_legacy_voltage_select,
  output logic o_clkrun_stop_ok,
  output logic o_ring_wake_pin
);
  logic [15:0] ctl_ff, nxt_ctl;
  logic socket_activity_flag_ff, nxt_socket_activity_flag;
  logic power_serial_busy_ff, nxt_power_serial_busy;
  logic power_rise_wait_ff, nxt_power_rise_wait;
  logic power_fall_wait_ff, nxt_power_fall_wait;
  logic card_probe_busy_ff, nxt_card_probe_busy;
  logic [15:0] rdata_ff, nxt_rdata;
  logic [8:0] out_ff, nxt_out;
  logic hit_wr, hit_rd;
  logic [15:0] wmask, view;

  assign hit_wr = i_cfg_wr && (i_cfg_addr == SYSCTL_OFFSET);
  assign hit_rd = i_cfg_rd && (i_cfg_addr == SYSCTL_OFFSET);
  assign wmask = {{8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}} & RW_MASK;

  always_comb begin
    view = ctl_ff & RW_MASK;
    view[B_SOCK_ACT] = socket_activity_flag_ff;
    view[B_RSVD12] = 1'b1;
    view[B_PWR_BUSY] = power_serial_busy_ff;
    view[B_RISE_WAIT] = power_rise_wait_ff;
    view[B_FALL_WAIT] = power_fall_wait_ff;
    view[B_PROBE] = card_probe_busy_ff;
  end

  always_comb begin
    nxt_ctl = ctl_ff;
    if (hit_wr) begin
      // Status positions are outside the write mask
      nxt_ctl = (ctl_ff & ~wmask) | (i_cfg_wdata & wmask);
    end
    nxt_rdata = hit_rd ? view : 16'h0000;
  end

  always_comb begin
    // Set wins over the read clear
    nxt_socket_activity_flag = i_events.card_access || (socket_activity_flag_ff && !hit_rd);
    nxt_power_serial_busy = power_serial_busy_ff;
    if (i_events.pwr_stream_active) begin
      nxt_power_serial_busy = 1'b1;
    end else if (!power_rise_wait_ff && !power_fall_wait_ff && !i_events.pwr_stream_done) begin
      nxt_power_serial_busy = 1'b0;
    end
    nxt_power_rise_wait = power_rise_wait_ff;
    if (i_events.pwr_stream_done && i_events.pwr_stream_up) begin
      nxt_power_rise_wait = 1'b1;
    end else if (i_events.rise_delay_done) begin
      nxt_power_rise_wait = 1'b0;
    end
    nxt_power_fall_wait = power_fall_wait_ff;
    if (i_events.pwr_stream_done && !i_events.pwr_stream_up) begin
      nxt_power_fall_wait = 1'b1;
    end else if (i_events.fall_delay_done) begin
      nxt_power_fall_wait = 1'b0;
    end
    nxt_card_probe_busy = i_events.probe_active;
  end

  always_comb begin
    nxt_out[0] = ctl_ff[B_DN_BURST];
    nxt_out[1] = ctl_ff[B_UP_BURST];
    nxt_out[2] = ctl_ff[B_AUTO_SW] && i_legacy_auto_sw;
    nxt_out[3] = !(ctl_ff[B_IDLE_GATE] && i_card.card_present && i_card.card_idle
                   && i_card.card_clk_stopped);
    nxt_out[4] = ctl_ff[B_ID_LOCK];
    nxt_out[5] = ctl_ff[B_PAR_REP] && i_card.card_parity_err;
    nxt_out[6] = ctl_ff[B_LEG_VOLT];
    nxt_out[7] = i_clkrun_stop_req && !ctl_ff[B_CLK_INH];
    if (ctl_ff[B_PIN_MUX]) begin
      nxt_out[8] = i_card.wake_req;
    end else if (i_card.ring_req || !i_card.wake_en) begin
      nxt_out[8] = i_card.ring_req;
    end else begin
      nxt_out[8] = i_card.wake_req;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctl_ff <= SYSCTL_RESET;
      rdata_ff <= 16'h0000;
    end else begin
      ctl_ff <= nxt_ctl;
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      socket_activity_flag_ff <= 1'b0;
      power_serial_busy_ff <= 1'b0;
      power_rise_wait_ff <= 1'b0;
      power_fall_wait_ff <= 1'b0;
      card_probe_busy_ff <= 1'b0;
    end else begin
      socket_activity_flag_ff <= nxt_socket_activity_flag;
      power_serial_busy_ff <= nxt_power_serial_busy;
      power_rise_wait_ff <= nxt_power_rise_wait;
      power_fall_wait_ff <= nxt_power_fall_wait;
      card_probe_busy_ff <= nxt_card_probe_busy;
    end
  end

  // Output levels must match the reset control word while reset is held
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_ff <= OUT_RESET;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign o_cfg_rdata = rdata_ff;
  assign o_down_read_burst_en = out_ff[0];
  assign o_up_read_burst_en = out_ff[1];
  assign o_auto_switch_active = out_ff[2];
  assign o_card_fsm_clk_en = out_ff[3];
  assign o_id_write_lock = out_ff[4];
  assign o_serr_req = out_ff[5];
  assign o_legacy_voltage_select = out_ff[6];
  assign o_clkrun_stop_ok = out_ff[7];
  assign o_ring_wake_pin = out_ff[8];

  burst_follow_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    ##1 o_down_read_burst_en == $past(ctl_ff[B_DN_BURST])) else $error("down burst not following control");
  up_burst_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    hit_wr && i_cfg_be[1] |=> ##1 o_up_read_burst_en == $past(i_cfg_wdata[B_UP_BURST], 2))
    else $error("up burst not following write");
  activity_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_events.card_access |=> socket_activity_flag_ff) else $error("activity lost");
  activity_clr_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    hit_rd && !i_events.card_access |=> !socket_activity_flag_ff) else $error("activity not cleared on read");
  rsvd_one_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    hit_rd |=> o_cfg_rdata[B_RSVD12]) else $error("bit 12 not one");
  rise_wait_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_events.pwr_stream_done && i_events.pwr_stream_up |=> power_rise_wait_ff) else $error("rise wait not set");
  fall_wait_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_events.pwr_stream_done && !i_events.pwr_stream_up |=> power_fall_wait_ff) else $error("fall wait not set");
  probe_follow_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    ##1 card_probe_busy_ff == $past(i_events.probe_active)) else $error("probe flag wrong");
  clock_inhibit_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    ctl_ff[B_CLK_INH] |=> !o_clkrun_stop_ok) else $error("clock stop allowed while inhibited");
  status_wr_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    hit_wr |=> (ctl_ff & ~RW_MASK) == (SYSCTL_RESET & ~RW_MASK)) else $error("status written");

  // Power sequencing, routing and read-back
  busy_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_events.pwr_stream_active
    |=> power_serial_busy_ff)
    else $error("power busy not set by stream");
  busy_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    power_serial_busy_ff && (power_rise_wait_ff || power_fall_wait_ff)
    |=> power_serial_busy_ff)
    else $error("power busy dropped during settling");
  busy_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    power_serial_busy_ff && !i_events.pwr_stream_active && !i_events.pwr_stream_done && !power_rise_wait_ff
    && !power_fall_wait_ff |=> !power_serial_busy_ff)
    else $error("power busy not cleared");
  rise_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_events.rise_delay_done && !(i_events.pwr_stream_done && i_events.pwr_stream_up)
    |=> !power_rise_wait_ff)
    else $error("rise wait not cleared");
  rise_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    power_rise_wait_ff && !i_events.rise_delay_done
    |=> power_rise_wait_ff)
    else $error("rise wait cleared early");
  fall_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_events.fall_delay_done && !(i_events.pwr_stream_done && !i_events.pwr_stream_up)
    |=> !power_fall_wait_ff)
    else $error("fall wait not cleared");
  fall_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    power_fall_wait_ff && !i_events.fall_delay_done
    |=> power_fall_wait_ff)
    else $error("fall wait cleared early");
  auto_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !ctl_ff[B_AUTO_SW]
    |=> !o_auto_switch_active)
    else $error("auto switch active while gated off");
  auto_on_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    ctl_ff[B_AUTO_SW] && i_legacy_auto_sw
    |=> o_auto_switch_active)
    else $error("auto switch not passed through");
  idle_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    ctl_ff[B_IDLE_GATE] && i_card.card_present && i_card.card_idle && i_card.card_clk_stopped
    |=> !o_card_fsm_clk_en)
    else $error("idle card state machine still clocked");
  clock_run_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !ctl_ff[B_IDLE_GATE]
    |=> o_card_fsm_clk_en)
    else $error("card state machine gated with savings off");
  id_lock_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    ##1
    o_id_write_lock == $past(ctl_ff[B_ID_LOCK]))
    else $error("id lock not following control");
  lock_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    hit_wr && i_cfg_be[0]
    |=> ##1 o_id_write_lock == $past(i_cfg_wdata[B_ID_LOCK], 2))
    else $error("id lock not following write");
  parity_report_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    ctl_ff[B_PAR_REP] && i_card.card_parity_err
    |=> o_serr_req)
    else $error("parity error not reported");
  parity_mute_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !ctl_ff[B_PAR_REP]
    |=> !o_serr_req)
    else $error("parity error reported while disabled");
  volt_select_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    ##1
    o_legacy_voltage_select == $past(ctl_ff[B_LEG_VOLT]))
    else $error("voltage select not following control");
  clock_stop_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !ctl_ff[B_CLK_INH] && i_clkrun_stop_req
    |=> o_clkrun_stop_ok)
    else $error("clock stop refused while allowed");
  wake_only_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    ctl_ff[B_PIN_MUX]
    |=> o_ring_wake_pin == $past(i_card.wake_req))
    else $error("pin not carrying wake only");
  shared_ring_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !ctl_ff[B_PIN_MUX] && !i_card.wake_en
    |=> o_ring_wake_pin == $past(i_card.ring_req))
    else $error("shared pin not carrying ring");
  ring_wins_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !ctl_ff[B_PIN_MUX] && i_card.wake_en && i_card.ring_req
    |=> o_ring_wake_pin)
    else $error("ring lost on shared pin");
  down_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    hit_wr && i_cfg_be[1]
    |=> ##1 o_down_read_burst_en == $past(i_cfg_wdata[B_DN_BURST], 2))
    else $error("down burst not following write");
  activity_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    hit_rd
    |=> o_cfg_rdata[B_SOCK_ACT] == $past(socket_activity_flag_ff))
    else $error("activity flag not read back");
  activity_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    socket_activity_flag_ff && !hit_rd
    |=> socket_activity_flag_ff)
    else $error("activity flag lost without read");
  busy_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    hit_rd
    |=> o_cfg_rdata[B_PWR_BUSY] == $past(power_serial_busy_ff))
    else $error("power busy not read back");
  rise_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    hit_rd
    |=> o_cfg_rdata[B_RISE_WAIT] == $past(power_rise_wait_ff))
    else $error("rise wait not read back");
  fall_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    hit_rd
    |=> o_cfg_rdata[B_FALL_WAIT] == $past(power_fall_wait_ff))
    else $error("fall wait not read back");
  probe_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    hit_rd
    |=> o_cfg_rdata[B_PROBE] == $past(card_probe_busy_ff))
    else $error("probe flag not read back");
  rsvd_keep_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    hit_wr
    |=> ctl_ff[B_RSVD12])
    else $error("bit 12 changed by write");
endmodule

// *** rtl/sysctl_pkg.sv ***
// Package: field positions, reset values and carriers of the system control low half
package sysctl_pkg;
  localparam logic [7:0] SYSCTL_OFFSET = 8'h80;
  localparam int B_DN_BURST = 15;
  localparam int B_UP_BURST = 14;
  localparam int B_SOCK_ACT = 13;
  localparam int B_RSVD12 = 12;
  localparam int B_PWR_BUSY = 11;
  localparam int B_RISE_WAIT = 10;
  localparam int B_FALL_WAIT = 9;
  localparam int B_PROBE = 8;
  localparam int B_AUTO_SW = 7;
  localparam int B_IDLE_GATE = 6;
  localparam int B_ID_LOCK = 5;
  localparam int B_PAR_REP = 4;
  localparam int B_RSVD3 = 3;
  localparam int B_LEG_VOLT = 2;
  localparam int B_CLK_INH = 1;
  localparam int B_PIN_MUX = 0;
  localparam logic [15:0] SYSCTL_RESET = 16'h9060;
  // Writable control positions 15,14,7..0
  localparam logic [15:0] RW_MASK = 16'hC0FF;
  // Registered output levels in reset: down burst, card clock enable and id lock high
  localparam logic [8:0] OUT_RESET = 9'h019;

  // Events from the rest of the bridge
  typedef struct packed {
    logic card_access;
    logic pwr_stream_active;
    logic pwr_stream_up;
    logic pwr_stream_done;
    logic rise_delay_done;
    logic fall_delay_done;
    logic probe_active;
  } sys_events_t;

  // Card-side status used for gating and routing
  typedef struct packed {
    logic card_present;
    logic card_idle;
    logic card_clk_stopped;
    logic card_parity_err;
    logic ring_req;
    logic wake_req;
    logic wake_en;
  } card_status_t;
endpackage

// *** bench/card_bridge_system_control_low_test.sv ***
// Self-checking testbench for the system control low half
`timescale 1ns/1ps
module card_bridge_system_control_low_test;
  import sysctl_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_cfg_wr = 1'b0;
  logic i_cfg_rd = 1'b0;
  logic [7:0] i_cfg_addr = 8'h00;
  logic [1:0] i_cfg_be = 2'h0;
  logic [15:0] i_cfg_wdata = 16'h0000;
  sys_events_t i_events = '0;
  card_status_t i_card = '0;
  logic i_legacy_auto_sw = 1'b0;
  logic i_clkrun_stop_req = 1'b0;
  logic [15:0] o_cfg_rdata;
  logic o_dn, o_up, o_auto, o_fsm, o_lock, o_serr, o_volt, o_stop, o_pin;
  wire logic [15:0] outs = {7'h00, o_dn, o_up, o_auto, o_fsm, o_lock, o_serr, o_volt, o_stop, o_pin};
  int num_errors = 0;
  int cmp_count = 0;

  always #10 i_sys_clk = ~i_sys_clk;

  card_bridge_system_control_low card_bridge_system_control_low_inst (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd),
    .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be), .i_cfg_wdata(i_cfg_wdata), .i_events(i_events),
    .i_card(i_card), .i_legacy_auto_sw(i_legacy_auto_sw), .i_clkrun_stop_req(i_clkrun_stop_req),
    .o_cfg_rdata(o_cfg_rdata), .o_down_read_burst_en(o_dn), .o_up_read_burst_en(o_up),
    .o_auto_switch_active(o_auto), .o_card_fsm_clk_en(o_fsm), .o_id_write_lock(o_lock),
    .o_serr_req(o_serr), .o_legacy_voltage_select(o_volt), .o_clkrun_stop_ok(o_stop),
    .o_ring_wake_pin(o_pin));

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] d, input logic [1:0] be);
    @(posedge i_sys_clk);
    i_cfg_wr <= 1'b1;
    i_cfg_addr <= SYSCTL_OFFSET;
    i_cfg_be <= be;
    i_cfg_wdata <= d;
    @(posedge i_sys_clk);
    i_cfg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_sys_clk);
    i_cfg_rd <= 1'b1;
    i_cfg_addr <= a;
    @(posedge i_sys_clk);
    i_cfg_rd <= 1'b0;
    #1 chk("register", exp, o_cfg_rdata);
    @(posedge i_sys_clk);
    #1 chk("register idle", 16'h0000, o_cfg_rdata);
  endtask

  // Settle outputs, then compare the packed output levels
  task automatic outchk(input logic [15:0] exp);
    repeat (3) @(posedge i_sys_clk);
    #1 chk("outputs", exp, outs);
  endtask

  // Apply one event word for a cycle, then hold the second word
  task automatic ev(input sys_events_t e, input sys_events_t hold);
    @(posedge i_sys_clk);
    i_events <= e;
    @(posedge i_sys_clk);
    i_events <= hold;
    repeat (2) @(posedge i_sys_clk);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge i_sys_clk);
    num_errors++;
    stop_test;
  end

  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    rd(SYSCTL_OFFSET, SYSCTL_RESET);
    outchk(16'h0130);
    rd(8'h84, 16'h0000);
    @(posedge i_sys_clk);
    i_legacy_auto_sw <= 1'b1;
    i_clkrun_stop_req <= 1'b1;
    i_card <= 7'b1111101;
    wr(16'hFFF7, 2'h3);
    rd(SYSCTL_OFFSET, 16'hD0F7);
    outchk(16'h01DC);
    wr(16'h0000, 2'h1);
    rd(SYSCTL_OFFSET, 16'hD000);
    outchk(16'h01A3);
    wr(16'h0000, 2'h2);
    outchk(16'h0023);
    ev(7'b1000000, 7'b0000000);
    rd(SYSCTL_OFFSET, 16'h3000);
    rd(SYSCTL_OFFSET, 16'h1000);
    ev(7'b0100001, 7'b0100001);
    rd(SYSCTL_OFFSET, 16'h1900);
    ev(7'b0011000, 7'b0000000);
    rd(SYSCTL_OFFSET, 16'h1C00);
    ev(7'b0000100, 7'b0000000);
    rd(SYSCTL_OFFSET, 16'h1000);
    ev(7'b0101000, 7'b0000000);
    rd(SYSCTL_OFFSET, 16'h1A00);
    ev(7'b0000010, 7'b0000000);
    rd(SYSCTL_OFFSET, 16'h1000);
    @(posedge i_sys_clk);
    i_events <= 7'b1000000;
    i_cfg_rd <= 1'b1;
    i_cfg_addr <= SYSCTL_OFFSET;
    @(posedge i_sys_clk);
    i_events <= 7'b0000000;
    i_cfg_rd <= 1'b0;
    rd(SYSCTL_OFFSET, 16'h3000);
    rd(SYSCTL_OFFSET, 16'h1000);
    @(posedge i_sys_clk);
    i_card <= 7'b0000010;
    outchk(16'h0022);
    wr(16'h0001, 2'h1);
    outchk(16'h0023);
    @(posedge i_sys_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1 chk("reset outputs", 16'h0130, outs);
    chk("reset read data", 16'h0000, o_cfg_rdata);
    @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    rd(SYSCTL_OFFSET, SYSCTL_RESET);
    stop_test;
  end
endmodule
